// File: verilog/gric_pkg.sv
// Package for the graphics reset and initialization control block.
// Assumes a single 125 MHz system clock that stands in for the host bus clock.
`default_nettype none
package gric_pkg;
    // Register byte addresses on the plain register port (byte address = index * 4).
    localparam logic [7:0] GRIC_ADDR_RESET_CTRL = 8'h00;
    localparam logic [7:0] GRIC_ADDR_OPTION = 8'h04;
    localparam logic [7:0] GRIC_ADDR_CLASS = 8'h08;
    localparam logic [7:0] GRIC_ADDR_ROM_BASE = 8'h0c;
    localparam logic [7:0] GRIC_ADDR_INDEX = 8'h10;
    localparam logic [7:0] GRIC_ADDR_DATA = 8'h14;
    localparam logic [7:0] GRIC_ADDR_OPERATING_MODE_REG = 8'h18;
    localparam logic [7:0] GRIC_ADDR_PAGE_EXT = 8'h1c;
    localparam logic [7:0] GRIC_ADDR_STATUS = 8'h20;
    // Option register field positions.
    localparam int GRIC_OPT_FLASH_WR = 0;
    localparam int GRIC_OPT_NO_GDIV = 1;
    localparam int GRIC_OPT_INTERLEAVE = 2;
    localparam int GRIC_OPT_BIG_ENDIAN = 3;
    localparam int GRIC_OPT_VGA_IO_EN = 4;
    localparam int GRIC_OPT_ROM_PRESENT = 5;
    localparam int GRIC_OPT_RFH_LO = 8;
    localparam int GRIC_OPT_STRAP_ID_LO = 16;
    // Reset control bit and class register strap position.
    localparam int GRIC_RST_SOFT_BIT = 0;
    localparam int GRIC_CLASS_VGA_BIT = 23;
    // Class codes chosen by the VGA boot strap.
    localparam logic [23:0] GRIC_CLASS_SVGA = 24'h030000;
    localparam logic [23:0] GRIC_CLASS_OTHER = 24'h038000;
    // Reset values.
    localparam logic [3:0] GRIC_RFH_RESET = 4'h0;
    localparam logic [1:0] GRIC_SWAP_RESET = 2'h0;
    localparam logic [31:0] GRIC_ROM_BASE_RESET = 32'h00000000;
    // Host reset must stay low for more than this many host clocks.
    localparam int GRIC_HRST_MIN_CLKS = 2;
    localparam logic [2:0] GRIC_HRST_COUNT_MAX = 3'(GRIC_HRST_MIN_CLKS + 1);
    // Expansion reset length in clocks after a hard reset.
    localparam logic [3:0] GRIC_EXP_RST_CLKS = 4'h8;
    // Number of indirectly reachable registers.
    localparam int GRIC_INDIRECT_REGS = 8;
endpackage
`default_nettype wire

// File: verilog/gric_reset_init.sv
// Reset, strap capture and board configuration for the graphics controller.
// Assumes strap pins are stable while the host reset pin is low.
// Notes on behaviour
// R1 - Hard reset only after reset pin exceeds two clocks.
// R2 - Hard reset restores registers and state machines.
// R3 - Hard reset empties FIFOs and invalidates cache.
// R4 - Hard reset drives expansion reset, host clock synchronous.
// R5 - Straps caught at hard reset only.
// R6 - ROM strap gates ROM base writes, drives field.
// R7 - VGA strap is class bit 23, picks class.
// R8 - VGA strap sets decode until software writes.
// R9 - Soft reset bit holds reset until cleared.
// R10 - Soft reset hits only the engine path.
// R11 - Option fields reset zero; bypass skips divide-by-four.
// R12 - Refresh field four bits, resets zero.
// R13 - VGA decode enable loads strap, stays writable.
// R14 - Software sets interleave only with enough memory.
// R15 - Software follows power-up programming order.
// R16 - Software holds soft reset at least 200 us.
// R17 - Software then retraces, memory reset, fills.
// R18 - Software repeats sequence on each soft reset.
// R19 - Software follows mode switch order.
// R20 - Index and data pair reach registers indirectly.
// R21 - VGA mode exposes one megabyte only.
// R22 - Direct access concurrent; two-bit swap field.
// R23 - No plane masking on direct access.
// R24 - Host reset pin synchronised before counting.
`default_nettype none
module gric_reset_init
    import gric_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic host_reset_n,
    input wire logic [6:0] strap_pins,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic engine_idle,
    output logic [31:0] reg_rdata,
    output logic hard_reset_ff,
    output logic expansion_reset_n,
    output logic engine_reset,
    output logic fifo_flush,
    output logic vga_io_decode,
    output logic gclk_div_bypass,
    output logic flash_write_en,
    output logic mem_interleave,
    output logic big_endian_en,
    output logic [3:0] refresh_count,
    output logic [1:0] fb_swap_mode,
    output logic fb_plane_mask_en,
    output logic vga_window_1mb
);
    typedef enum logic [1:0] {
        GRIC_HR_IDLE,
        GRIC_HR_COUNT,
        GRIC_HR_ACTIVE
    } gric_hr_state_type;

    // Two-stage synchroniser for the asynchronous host reset pin.
    logic hrst_meta_ff, hrst_sync_ff;
    always_ff @(posedge clk_sys) begin
        hrst_meta_ff <= host_reset_n; // see R24
        hrst_sync_ff <= hrst_meta_ff;
    end

    gric_hr_state_type hr_state_ff, nxt_hr_state;
    logic [2:0] hr_cnt_ff, nxt_hr_cnt;
    logic hard_reset_nxt;
    logic [3:0] exp_cnt_ff, nxt_exp_cnt;
    logic exp_n_nxt, strap_load;

    // Pulse-width filter: the pin must stay low for more than two clocks.
    always_comb begin
        nxt_hr_state = hr_state_ff;
        nxt_hr_cnt = hr_cnt_ff;
        case (hr_state_ff)
            GRIC_HR_IDLE: begin
                nxt_hr_cnt = 3'h0;
                if (!hrst_sync_ff) begin
                    nxt_hr_state = GRIC_HR_COUNT;
                    nxt_hr_cnt = 3'h1;
                end
            end
            GRIC_HR_COUNT: begin
                if (hrst_sync_ff) begin
                    nxt_hr_state = GRIC_HR_IDLE; // see R1
                end else if (hr_cnt_ff == GRIC_HRST_COUNT_MAX - 3'h1) begin
                    nxt_hr_state = GRIC_HR_ACTIVE;
                end else begin
                    nxt_hr_cnt = hr_cnt_ff + 3'h1;
                end
            end
            GRIC_HR_ACTIVE: begin
                if (hrst_sync_ff) begin
                    nxt_hr_state = GRIC_HR_IDLE;
                end
            end
            default: nxt_hr_state = GRIC_HR_IDLE;
        endcase
        hard_reset_nxt = (nxt_hr_state == GRIC_HR_ACTIVE); // see R1
    end

    // Expansion reset runs during hard reset and a short tail after it.
    always_comb begin
        nxt_exp_cnt = exp_cnt_ff;
        if (hard_reset_ff) begin
            nxt_exp_cnt = GRIC_EXP_RST_CLKS; // see R4
        end else if (exp_cnt_ff != 4'h0) begin
            nxt_exp_cnt = exp_cnt_ff - 4'h1;
        end
        exp_n_nxt = !(hard_reset_nxt || nxt_exp_cnt != 4'h0); // falls with hard reset, see R4
        strap_load = hard_reset_ff && !hard_reset_nxt; // catch at release, see R5
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hr_state_ff <= GRIC_HR_ACTIVE;
            hr_cnt_ff <= 3'h0;
            hard_reset_ff <= 1'b1;
            exp_cnt_ff <= GRIC_EXP_RST_CLKS;
            expansion_reset_n <= 1'b0;
        end else begin
            hr_state_ff <= nxt_hr_state;
            hr_cnt_ff <= nxt_hr_cnt;
            hard_reset_ff <= hard_reset_nxt;
            exp_cnt_ff <= nxt_exp_cnt;
            expansion_reset_n <= exp_n_nxt; // see R4
        end
    end

    // Strap synchroniser; straps are caught only as hard reset ends.
    logic [6:0] strap_meta_ff, strap_sync_ff;
    always_ff @(posedge clk_sys) begin
        strap_meta_ff <= strap_pins;
        strap_sync_ff <= strap_meta_ff;
    end

    logic [4:0] strap_id_ff, nxt_strap_id;
    logic vga_boot_ff, nxt_vga_boot, rom_present_ff, nxt_rom_present;
    logic vga_io_en_ff, nxt_vga_io_en;
    logic soft_reset_ff, nxt_soft_reset;
    logic flash_wr_ff, nxt_flash_wr, no_gdiv_ff, nxt_no_gdiv;
    logic interleave_ff, nxt_interleave, big_end_ff, nxt_big_end;
    logic [3:0] rfh_ff, nxt_rfh;
    logic [1:0] swap_ff, nxt_swap;
    logic [7:0] page_ext_ff, nxt_page_ext;
    logic [31:0] rom_base_ff, nxt_rom_base;
    logic [2:0] index_ff, nxt_index;
    logic [31:0] rdata_nxt;

    // Decode of a register index into a byte address on the port.
    function automatic logic [7:0] gric_idx_addr(input logic [2:0] idx);
        gric_idx_addr = {3'h0, idx, 2'h0};
    endfunction

    // Read value of one register at a given address.
    function automatic logic [31:0] gric_read(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        if (a == GRIC_ADDR_RESET_CTRL) begin
            v[GRIC_RST_SOFT_BIT] = soft_reset_ff;
        end else if (a == GRIC_ADDR_OPTION) begin
            v[GRIC_OPT_FLASH_WR] = flash_wr_ff;
            v[GRIC_OPT_NO_GDIV] = no_gdiv_ff;
            v[GRIC_OPT_INTERLEAVE] = interleave_ff;
            v[GRIC_OPT_BIG_ENDIAN] = big_end_ff;
            v[GRIC_OPT_VGA_IO_EN] = vga_io_en_ff;
            v[GRIC_OPT_ROM_PRESENT] = rom_present_ff; // see R6
            v[GRIC_OPT_RFH_LO +: 4] = rfh_ff;
            v[GRIC_OPT_STRAP_ID_LO +: 5] = strap_id_ff;
        end else if (a == GRIC_ADDR_CLASS) begin
            v[31:8] = vga_boot_ff ? GRIC_CLASS_SVGA : GRIC_CLASS_OTHER; // see R7
        end else if (a == GRIC_ADDR_ROM_BASE) begin
            v = rom_base_ff;
        end else if (a == GRIC_ADDR_INDEX) begin
            v[4:2] = index_ff;
        end else if (a == GRIC_ADDR_OPERATING_MODE_REG) begin
            v[1:0] = swap_ff;
        end else if (a == GRIC_ADDR_PAGE_EXT) begin
            v[7:0] = page_ext_ff;
        end else if (a == GRIC_ADDR_STATUS) begin
            v[0] = engine_idle;
            v[1] = hard_reset_ff;
        end
        gric_read = v;
    endfunction

    // Register writes; a data-port access is redirected through the index.
    always_comb begin
        logic [7:0] wa;
        wa = (reg_addr == GRIC_ADDR_DATA) ? gric_idx_addr(index_ff) : reg_addr; // see R20
        nxt_strap_id = strap_id_ff;
        nxt_vga_boot = vga_boot_ff;
        nxt_rom_present = rom_present_ff;
        nxt_vga_io_en = vga_io_en_ff;
        nxt_soft_reset = soft_reset_ff;
        nxt_flash_wr = flash_wr_ff;
        nxt_no_gdiv = no_gdiv_ff;
        nxt_interleave = interleave_ff;
        nxt_big_end = big_end_ff;
        nxt_rfh = rfh_ff;
        nxt_swap = swap_ff;
        nxt_page_ext = page_ext_ff;
        nxt_rom_base = rom_base_ff;
        nxt_index = index_ff;
        if (strap_load) begin
            nxt_rom_present = strap_sync_ff[6]; // see R5
            nxt_vga_boot = strap_sync_ff[5];
            nxt_strap_id = strap_sync_ff[4:0];
            nxt_vga_io_en = strap_sync_ff[5]; // see R8, R13
        end else if (reg_wr && !hard_reset_ff) begin
            if (wa == GRIC_ADDR_RESET_CTRL) begin
                nxt_soft_reset = reg_wdata[GRIC_RST_SOFT_BIT]; // see R9
            end else if (wa == GRIC_ADDR_OPTION) begin
                nxt_flash_wr = reg_wdata[GRIC_OPT_FLASH_WR];
                nxt_no_gdiv = reg_wdata[GRIC_OPT_NO_GDIV];
                nxt_interleave = reg_wdata[GRIC_OPT_INTERLEAVE];
                nxt_big_end = reg_wdata[GRIC_OPT_BIG_ENDIAN];
                nxt_vga_io_en = reg_wdata[GRIC_OPT_VGA_IO_EN]; // see R13
                nxt_rfh = reg_wdata[GRIC_OPT_RFH_LO +: 4]; // see R12
            end else if (wa == GRIC_ADDR_ROM_BASE && rom_present_ff) begin
                nxt_rom_base = reg_wdata; // see R6
            end else if (wa == GRIC_ADDR_INDEX) begin
                nxt_index = reg_wdata[4:2];
            end else if (wa == GRIC_ADDR_OPERATING_MODE_REG) begin
                nxt_swap = reg_wdata[1:0]; // see R22
            end else if (wa == GRIC_ADDR_PAGE_EXT) begin
                nxt_page_ext = reg_wdata[7:0];
            end
        end
        rdata_nxt = 32'h0;
        if (reg_rd) begin
            rdata_nxt = gric_read((reg_addr == GRIC_ADDR_DATA) ?
                                  gric_idx_addr(index_ff) : reg_addr);
        end
    end

    // Hard reset returns the other registers to reset values; these strap registers reload from the pins as it ends.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strap_id_ff <= 5'h00;
            vga_boot_ff <= 1'b0;
            rom_present_ff <= 1'b0;
            vga_io_en_ff <= 1'b0;
        end else begin
            strap_id_ff <= nxt_strap_id;
            vga_boot_ff <= nxt_vga_boot;
            rom_present_ff <= nxt_rom_present;
            vga_io_en_ff <= nxt_vga_io_en; // soft reset leaves this, see R5
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || hard_reset_ff) begin // see R2
            soft_reset_ff <= 1'b0;
            flash_wr_ff <= 1'b0; // see R11
            no_gdiv_ff <= 1'b0;
            interleave_ff <= 1'b0;
            big_end_ff <= 1'b0;
            rfh_ff <= GRIC_RFH_RESET; // see R12
            swap_ff <= GRIC_SWAP_RESET;
            page_ext_ff <= 8'h00;
            rom_base_ff <= GRIC_ROM_BASE_RESET;
            index_ff <= 3'h0;
            reg_rdata <= 32'h0;
        end else begin
            soft_reset_ff <= nxt_soft_reset;
            flash_wr_ff <= nxt_flash_wr;
            no_gdiv_ff <= nxt_no_gdiv;
            interleave_ff <= nxt_interleave;
            big_end_ff <= nxt_big_end;
            rfh_ff <= nxt_rfh;
            swap_ff <= nxt_swap;
            page_ext_ff <= nxt_page_ext;
            rom_base_ff <= nxt_rom_base;
            index_ff <= nxt_index;
            reg_rdata <= rdata_nxt;
        end
    end

    // Output stage; engine reset and flush cover only the engine path.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            engine_reset <= 1'b1;
            fifo_flush <= 1'b1;
            vga_io_decode <= 1'b0;
            gclk_div_bypass <= 1'b0;
            flash_write_en <= 1'b0;
            mem_interleave <= 1'b0;
            big_endian_en <= 1'b0;
            refresh_count <= GRIC_RFH_RESET;
            fb_swap_mode <= GRIC_SWAP_RESET;
            fb_plane_mask_en <= 1'b0;
            vga_window_1mb <= 1'b1;
        end else begin
            engine_reset <= hard_reset_nxt || soft_reset_ff; // see R2, R10
            fifo_flush <= hard_reset_nxt || soft_reset_ff; // see R3
            vga_io_decode <= vga_io_en_ff; // see R8
            gclk_div_bypass <= no_gdiv_ff; // see R11
            flash_write_en <= flash_wr_ff;
            mem_interleave <= interleave_ff;
            big_endian_en <= big_end_ff;
            refresh_count <= rfh_ff;
            fb_swap_mode <= swap_ff; // see R22
            fb_plane_mask_en <= 1'b0; // see R23
            vga_window_1mb <= (page_ext_ff == 8'h00); // see R21
        end
    end
endmodule
`default_nettype wire

// File: verif/gric_reset_init_props.sv
// Checker for the graphics reset and initialization block.
// Assumes it is bound to the block's top module and sees only its ports.
`default_nettype none
module gric_reset_init_props
    import gric_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic host_reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic hard_reset_ff,
    input wire logic expansion_reset_n,
    input wire logic engine_reset,
    input wire logic fifo_flush,
    input wire logic vga_io_decode,
    input wire logic gclk_div_bypass,
    input wire logic flash_write_en,
    input wire logic mem_interleave,
    input wire logic big_endian_en,
    input wire logic [3:0] refresh_count,
    input wire logic fb_plane_mask_en,
    input wire logic vga_window_1mb
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks run on the system clock and rest while reset is high.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_short_pulse_ignored:
        assert property (!hard_reset_ff && host_reset_n ##1 !host_reset_n [*2]
            ##1 host_reset_n |-> !hard_reset_ff [*6]) else $error("short pulse reset");
    a_long_pulse_taken:
        assert property (!host_reset_n [*6] |-> ##[0:3] hard_reset_ff)
        else $error("long pulse ignored");
    a_exp_in_hard:
        assert property (hard_reset_ff |-> !expansion_reset_n) else $error("exp reset high");
    a_exp_tail_len:
        assert property ($fell(hard_reset_ff) |-> !expansion_reset_n [*6]
            ##[1:4] expansion_reset_n) else $error("exp reset tail wrong");
    a_hard_engine:
        assert property (hard_reset_ff |-> engine_reset && fifo_flush)
        else $error("engine not reset");
    a_fields_cleared:
        assert property ($fell(hard_reset_ff) |-> !flash_write_en && !gclk_div_bypass
            && !mem_interleave && !big_endian_en && refresh_count == GRIC_RFH_RESET)
        else $error("option fields not cleared");
    a_soft_reset_set:
        assert property (reg_wr && !hard_reset_ff && reg_addr == GRIC_ADDR_RESET_CTRL
            && reg_wdata[GRIC_RST_SOFT_BIT] |-> ##2 engine_reset && fifo_flush)
        else $error("soft reset not applied");
    a_soft_keeps_pins:
        assert property ($rose(engine_reset) && !hard_reset_ff |-> expansion_reset_n
            && $stable(vga_io_decode)) else $error("soft reset touched pins");
    a_no_plane_mask:
        assert property (!fb_plane_mask_en) else $error("plane mask on");
    a_page_window:
        assert property (reg_wr && !hard_reset_ff && reg_addr == GRIC_ADDR_PAGE_EXT
            && reg_wdata[7:0] != 8'h00 |-> ##2 !vga_window_1mb) else $error("window");
    c_soft: cover property ($rose(engine_reset) && !hard_reset_ff);
    c_hard: cover property ($rose(hard_reset_ff));
    c_window: cover property ($fell(vga_window_1mb));
endmodule
bind gric_reset_init gric_reset_init_props u_props (.clk_sys(clk_sys), .rst(rst),
    .host_reset_n(host_reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .hard_reset_ff(hard_reset_ff), .expansion_reset_n(expansion_reset_n),
    .engine_reset(engine_reset), .fifo_flush(fifo_flush), .vga_io_decode(vga_io_decode),
    .gclk_div_bypass(gclk_div_bypass), .flash_write_en(flash_write_en),
    .mem_interleave(mem_interleave), .big_endian_en(big_endian_en),
    .refresh_count(refresh_count), .fb_plane_mask_en(fb_plane_mask_en),
    .vga_window_1mb(vga_window_1mb));
`default_nettype wire

// File: verif/gric_host_model.sv
// Host software model that drives the block's plain register port.
// Assumes one clock and read data that stand in the cycle after the strobe.
`default_nettype none
module gric_host_model
    import gric_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [31:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    // The port stays quiet until software issues a request.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // A write is one strobe cycle with address and data beside it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // A read takes the data in the cycle after the strobe, and only there.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking testbench for the graphics reset and initialization block.
// Assumes the host model and the bound checker are compiled beside it.
`default_nettype none
module tb
    import gric_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, host_reset_n, engine_idle, reg_wr, reg_rd, hard_reset_ff;
    logic expansion_reset_n, engine_reset, fifo_flush, vga_io_decode, gclk_div_bypass;
    logic flash_write_en, mem_interleave, big_endian_en, fb_plane_mask_en, vga_window_1mb;
    logic [6:0] strap_pins;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic [3:0] refresh_count;
    logic [1:0] fb_swap_mode;
    int n_errors = 0;
    int total_checks = 0;
    // Software waits 200 us around the soft reset, counted in 8 ns clocks.
    localparam int SOFT_WAIT_CLKS = 25000;
    gric_reset_init DUT (.clk_sys(clk_sys), .rst(rst), .host_reset_n(host_reset_n),
        .strap_pins(strap_pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .engine_idle(engine_idle), .reg_rdata(reg_rdata),
        .hard_reset_ff(hard_reset_ff), .expansion_reset_n(expansion_reset_n),
        .engine_reset(engine_reset), .fifo_flush(fifo_flush), .vga_io_decode(vga_io_decode),
        .gclk_div_bypass(gclk_div_bypass), .flash_write_en(flash_write_en),
        .mem_interleave(mem_interleave), .big_endian_en(big_endian_en),
        .refresh_count(refresh_count), .fb_swap_mode(fb_swap_mode),
        .fb_plane_mask_en(fb_plane_mask_en), .vga_window_1mb(vga_window_1mb));
    gric_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    // The system clock runs at 125 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Values after the first hard reset, with a ROM and VGA boot strapped.
    task automatic t_reset_vals();
        host.rd(GRIC_ADDR_OPTION, rd_val);
        chk(rd_val & 32'hffffffdf, 32'h000a0010);
        host.rd(GRIC_ADDR_CLASS, rd_val);
        chk(32'(rd_val[31:8]), 32'(GRIC_CLASS_SVGA));
        host.wr(GRIC_ADDR_ROM_BASE, 32'h000c0000);
        host.rd(GRIC_ADDR_ROM_BASE, rd_val);
        chk(rd_val, 32'h000c0000);
        chk(32'({expansion_reset_n, engine_reset, fb_plane_mask_en}), 32'h4);
        $display("test reset values done");
    endtask
    // Board options; the board is taken to carry 4 MB and a wide DAC.
    task automatic t_options();
        host.wr(GRIC_ADDR_OPTION, 32'h0000091f);
        cyc(2);
        chk(32'({vga_io_decode, big_endian_en, mem_interleave, gclk_div_bypass,
            flash_write_en, refresh_count}), 32'h1f9);
        host.wr(GRIC_ADDR_OPTION, 32'h00000100);
        cyc(2);
        chk(32'({vga_io_decode, big_endian_en, mem_interleave, refresh_count}), 32'h1);
        $display("test options done");
    endtask
    // Soft reset holds until cleared and leaves pins and decode alone.
    task automatic t_soft();
        host.wr(GRIC_ADDR_OPTION, 32'h00000110);
        host.wr(GRIC_ADDR_RESET_CTRL, 32'h00000001);
        cyc(SOFT_WAIT_CLKS);
        chk(32'({engine_reset, fifo_flush, expansion_reset_n, vga_io_decode}), 32'hf);
        host.rd(GRIC_ADDR_OPTION, rd_val);
        chk(rd_val & 32'hffffffdf, 32'h000a0110);
        host.wr(GRIC_ADDR_RESET_CTRL, 32'h00000000);
        cyc(2);
        chk(32'(engine_reset), 32'h0);
        cyc(SOFT_WAIT_CLKS);
        engine_idle <= 1'b0;
        host.rd(GRIC_ADDR_STATUS, rd_val);
        chk(rd_val, 32'h00000000);
        engine_idle <= 1'b1;
        host.rd(GRIC_ADDR_STATUS, rd_val);
        chk(rd_val, 32'h00000001);
        $display("test soft reset done");
    endtask
    // Indirect access, swap field, page extension and an unmapped place.
    task automatic t_indirect();
        host.wr(GRIC_ADDR_INDEX, 32'(GRIC_ADDR_OPERATING_MODE_REG));
        host.wr(GRIC_ADDR_DATA, 32'h00000002);
        cyc(2);
        chk(32'(fb_swap_mode), 32'h2);
        host.rd(GRIC_ADDR_DATA, rd_val);
        chk(rd_val & 32'h3, 32'h2);
        host.wr(GRIC_ADDR_PAGE_EXT, 32'h00000001);
        cyc(2);
        chk(32'(vga_window_1mb), 32'h0);
        host.wr(GRIC_ADDR_PAGE_EXT, 32'h00000000);
        cyc(2);
        chk(32'(vga_window_1mb), 32'h1);
        host.rd(8'h24, rd_val);
        chk(rd_val, 32'h00000000);
        $display("test indirect done");
    endtask
    // Short pin pulse is ignored; a long one resamples new straps.
    task automatic t_glitch();
        @(posedge clk_sys) host_reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        host_reset_n <= 1'b1;
        cyc(10);
        chk(32'(hard_reset_ff), 32'h0);
        @(posedge clk_sys) host_reset_n <= 1'b0;
        strap_pins <= 7'h0a;
        cyc(6);
        chk(32'({hard_reset_ff, expansion_reset_n}), 32'h2);
        @(posedge clk_sys) host_reset_n <= 1'b1;
        for (int i = 0; i < 40 && expansion_reset_n !== 1'b1; i++) cyc(1);
        chk(32'({vga_io_decode, fb_swap_mode}), 32'h0);
        host.rd(GRIC_ADDR_OPTION, rd_val);
        chk(rd_val & 32'hffffffdf, 32'h000a0000);
        host.rd(GRIC_ADDR_CLASS, rd_val);
        chk(32'(rd_val[31:8]), 32'(GRIC_CLASS_OTHER));
        host.wr(GRIC_ADDR_ROM_BASE, 32'h000c0000);
        host.rd(GRIC_ADDR_ROM_BASE, rd_val);
        chk(rd_val, 32'h00000000);
        $display("test hard reset done");
    endtask
    // Main sequence: reset for 16 cycles, then every scenario in turn.
    initial begin
        rst = 1'b1;
        host_reset_n = 1'b1;
        engine_idle = 1'b1;
        strap_pins = 7'h6a;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        cyc(15);
        t_reset_vals();
        t_options();
        t_soft();
        t_indirect();
        t_glitch();
        conclude();
    end
    // Watchdog beyond the two 200 us soft reset waits and the short scenarios.
    initial begin
        #600000;
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
